// ==== src/rsc_reset_ctrl.v ====
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "rsc_regs.vh"
// Reset sources controller
module rsc_reset_ctrl #(
  parameter POR_CYCLES  = `RSC_POR_CYC,
  parameter WDT_CYCLES  = `RSC_WDT_CYC,
  parameter LOWV_CYCLES = 16'd200
) (
  // Clock and power-on reset
  input  wire        ref_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // External sources
  input  wire        ext_reset_n_pin,
  input  wire        low_supply,
  input  wire        wdog_timeout,
  input  wire        slow_osc_clock,
  input  wire        sleep_mode,
  // Reset outputs
  output reg         core_reset,
  output reg         pc_sp_clear,
  output reg  [7:0]  port_data_init,
  output reg  [7:0]  port_dir_init,
  output reg         port_init_load,
  output reg  [7:0]  lowv_level_select,
  output reg         wdog_timeout_status,
  output reg         powerdown_status,
  // Interrupt
  output wire        irq
);
  localparam ST_RUN   = 2'd0;
  localparam ST_HOLD  = 2'd1;
  localparam ST_SETTL = 2'd2;

  // Legal level-select code check
  function legal_code;
    input [7:0] c;
    begin
      legal_code = (c == `RSC_LV_2V10) || (c == `RSC_LV_2V55) ||
                   (c == `RSC_LV_3V15) || (c == `RSC_LV_3V80);
    end
  endfunction

  // Write strobe for one word index
  function wr_hit;
    input       en;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      wr_hit = en && (addr == ofs);
    end
  endfunction

  wire        pin_n_s;
  wire        lows_s;
  wire        wdt_s;
  wire        slp_s;
  wire        slow_tick;
  reg  [1:0]  state;
  reg  [31:0] settle_cnt;
  reg  [15:0] lowv_cnt;
  reg  [1:0]  bad_cnt;
  reg         wdt_d;
  reg         powerdown_ctrl;
  reg         lowv_reset_flag;
  reg         level_select_fault_flag;
  reg         wdog_ctrl_fault_flag;
  reg  [4:0]  irq_stat;
  reg  [4:0]  irq_en;
  reg         acked;
  wire        lowv_valid;
  wire        bad_fire;
  wire        wdt_rise;
  wire        wdt_normal;
  wire        wdt_sleep;
  wire        pin_low;
  wire        any_src;
  wire [4:0]  events;
  wire        wr_acc;
  wire        rd_acc;
  wire [3:0]  async_in;
  wire [3:0]  async_s;
  reg  [31:0] rd_word;
  genvar      gi;

  // Input synchronisers; the pin resets to its idle high level
  // so that no false pin reset follows power-on
  assign async_in = {sleep_mode, wdog_timeout, low_supply, ext_reset_n_pin};
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      rsc_sync #(
        .RST_VAL (gi == 0 ? 1'b1 : 1'b0)
      ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (async_in[gi]),
        .dout    (async_s[gi])
      );
    end
  endgenerate

  // Synchronised sources
  assign pin_n_s = async_s[0];
  assign lows_s  = async_s[1];
  assign wdt_s   = async_s[2];
  assign slp_s   = async_s[3];

  rsc_slow_tick u_tick (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .slow_osc_clock (slow_osc_clock),
    .tick           (slow_tick)
  );

  // Source decode
  assign pin_low    = ~pin_n_s;
  assign lowv_valid = (lowv_cnt == LOWV_CYCLES) & ~powerdown_ctrl;
  assign bad_fire   = (bad_cnt == 2'd2) & slow_tick;
  assign wdt_rise   = wdt_s & ~wdt_d;
  assign wdt_normal = wdt_rise & ~slp_s & (state == ST_RUN);
  assign wdt_sleep  = wdt_rise & slp_s & (state == ST_RUN);
  assign any_src    = pin_low | lowv_valid | bad_fire | wdt_normal;

  // Interrupt events, one per cause
  assign events[`RSC_EV_LOWV]     = lowv_valid & (state == ST_RUN);
  assign events[`RSC_EV_LEVEL]    = bad_fire;
  assign events[`RSC_EV_WDOG]     = wdt_normal;
  assign events[`RSC_EV_PIN]      = pin_low & (state == ST_RUN);
  assign events[`RSC_EV_SLEEP_TO] = wdt_sleep;

  // Low-supply persistence filter
  always @(posedge ref_clk) begin
    if (rst) begin
      lowv_cnt <= 16'h0000;
    end else if (!lows_s || powerdown_ctrl) begin
      lowv_cnt <= 16'h0000;
    end else if (lowv_cnt != LOWV_CYCLES) begin
      lowv_cnt <= lowv_cnt + 16'h0001;
    end
  end

  // Illegal level code counted in slow ticks
  always @(posedge ref_clk) begin
    if (rst || legal_code(lowv_level_select)) begin
      bad_cnt <= 2'd0;
    end else if (slow_tick && bad_cnt != 2'd2) begin
      bad_cnt <= bad_cnt + 2'd1;
    end
  end

  // Combined reset sequencer with settle counter
  always @(posedge ref_clk) begin
    if (rst) begin
      state          <= ST_SETTL;
      settle_cnt     <= POR_CYCLES;
      core_reset     <= 1'b1;
      pc_sp_clear    <= 1'b0;
      wdt_d          <= 1'b0;
      port_data_init <= `RSC_PORT_RST;
      port_dir_init  <= `RSC_PORT_RST;
      port_init_load <= 1'b1;
    end else begin
      wdt_d          <= wdt_s;
      pc_sp_clear    <= wdt_sleep;
      port_init_load <= 1'b0;
      case (state)
        ST_RUN: begin
          if (pin_low) begin
            state      <= ST_HOLD;
            core_reset <= 1'b1;
          end else if (any_src) begin
            state      <= ST_SETTL;
            core_reset <= 1'b1;
            settle_cnt <= wdt_normal && !lowv_valid && !bad_fire ?
                          WDT_CYCLES : POR_CYCLES;
          end
        end
        ST_HOLD: begin
          core_reset <= 1'b1;
          if (!pin_low) begin
            state      <= ST_SETTL;
            settle_cnt <= POR_CYCLES;
          end
        end
        ST_SETTL: begin
          core_reset <= 1'b1;
          if (pin_low) begin
            state <= ST_HOLD;
          end else if (lowv_valid || bad_fire) begin
            settle_cnt <= POR_CYCLES;
          end else if (settle_cnt <= 32'd1) begin
            state      <= ST_RUN;
            core_reset <= 1'b0;
          end else begin
            settle_cnt <= settle_cnt - 32'd1;
          end
        end
        default: begin
          state      <= ST_SETTL;
          core_reset <= 1'b1;
          settle_cnt <= POR_CYCLES;
        end
      endcase
    end
  end

  // Bus handshake: one wait cycle per access; read data loads in the
  // wait cycle so that it stands when waitrequest drops
  assign wr_acc          = avs_write & acked;
  assign rd_acc          = avs_read & ~acked;
  assign avs_waitrequest = (avs_read | avs_write) & ~acked;

  always @(posedge ref_clk) begin
    if (rst) begin
      acked <= 1'b0;
    end else begin
      acked <= (avs_read | avs_write) & ~acked;
    end
  end

  // Level select: a bad code restores the power-on code
  always @(posedge ref_clk) begin
    if (rst) begin
      lowv_level_select <= `RSC_LVSEL_RST;
    end else if (bad_fire) begin
      lowv_level_select <= `RSC_LVSEL_RST;
    end else if (wr_hit(wr_acc, avs_address, `RSC_OFS_LVSEL)) begin
      lowv_level_select <= avs_writedata[7:0];
    end
  end

  // Reset-cause flags: write 0 clears, hardware set wins
  always @(posedge ref_clk) begin
    if (rst) begin
      lowv_reset_flag         <= 1'b0;
      level_select_fault_flag <= 1'b0;
      wdog_ctrl_fault_flag    <= 1'b0;
    end else begin
      if (wr_hit(wr_acc, avs_address, `RSC_OFS_FLAGS)) begin
        if (!avs_writedata[`RSC_FLG_LOWV])
          lowv_reset_flag <= 1'b0;
        if (!avs_writedata[`RSC_FLG_LEVEL])
          level_select_fault_flag <= 1'b0;
        if (!avs_writedata[`RSC_FLG_WDOG])
          wdog_ctrl_fault_flag <= 1'b0;
      end
      if (lowv_valid)
        lowv_reset_flag <= 1'b1;
      if (!legal_code(lowv_level_select))
        level_select_fault_flag <= 1'b1;
    end
  end

  // Time-out and power-down status flags
  always @(posedge ref_clk) begin
    if (rst) begin
      wdog_timeout_status <= 1'b0;
      powerdown_status    <= 1'b0;
    end else begin
      if (wr_hit(wr_acc, avs_address, `RSC_OFS_STATUS)) begin
        wdog_timeout_status <= avs_writedata[`RSC_ST_TIMEOUT];
        powerdown_status    <= avs_writedata[`RSC_ST_PDOWN];
      end
      if (wdt_normal)
        wdog_timeout_status <= 1'b1;
      if (wdt_sleep) begin
        wdog_timeout_status <= 1'b1;
        powerdown_status    <= 1'b1;
      end
    end
  end

  // Power-down control
  always @(posedge ref_clk) begin
    if (rst) begin
      powerdown_ctrl <= 1'b0;
    end else if (wr_hit(wr_acc, avs_address, `RSC_OFS_CTRL)) begin
      powerdown_ctrl <= avs_writedata[`RSC_CTRL_PDOWN];
    end
  end

  // Interrupt enable and sticky status; an event beats a clear
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_en   <= 5'h00;
      irq_stat <= 5'h00;
    end else begin
      if (wr_hit(wr_acc, avs_address, `RSC_OFS_IRQ_EN))
        irq_en <= avs_writedata[4:0];
      if (wr_hit(wr_acc, avs_address, `RSC_OFS_IRQ_CLR))
        irq_stat <= (irq_stat & ~avs_writedata[4:0]) | events;
      else
        irq_stat <= irq_stat | events;
    end
  end

  assign irq = |(irq_stat & irq_en);

  // Read multiplexer
  always @* begin
    case (avs_address)
      `RSC_OFS_LVSEL:    rd_word = {24'h000000, lowv_level_select};
      `RSC_OFS_FLAGS:    rd_word = {29'h00000000, lowv_reset_flag,
                                    level_select_fault_flag,
                                    wdog_ctrl_fault_flag};
      `RSC_OFS_STATUS:   rd_word = {29'h00000000, state == ST_RUN,
                                    powerdown_status, wdog_timeout_status};
      `RSC_OFS_CTRL:     rd_word = {31'h00000000, powerdown_ctrl};
      `RSC_OFS_IRQ_STAT: rd_word = {27'h0000000, irq_stat};
      `RSC_OFS_IRQ_EN:   rd_word = {27'h0000000, irq_en};
      default:           rd_word = 32'h00000000;
    endcase
  end

  // Read data register, loaded in the wait cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_acc) begin
      avs_readdata <= rd_word;
    end
  end
endmodule

// ==== src/rsc_regs.vh ====
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// Register offsets (word addresses, one word each)
`define RSC_OFS_LVSEL     4'h0
`define RSC_OFS_FLAGS     4'h1
`define RSC_OFS_STATUS    4'h2
`define RSC_OFS_CTRL      4'h3
`define RSC_OFS_IRQ_STAT  4'h4
`define RSC_OFS_IRQ_EN    4'h5
`define RSC_OFS_IRQ_CLR   4'h6
// Level-select codes and reset value
`define RSC_LV_2V10       8'h55
`define RSC_LV_2V55       8'h33
`define RSC_LV_3V15       8'h99
`define RSC_LV_3V80       8'hAA
`define RSC_LVSEL_RST     8'h55
// Flag bit positions
`define RSC_FLG_LOWV      2
`define RSC_FLG_LEVEL     1
`define RSC_FLG_WDOG      0
`define RSC_ST_TIMEOUT    0
`define RSC_ST_PDOWN      1
`define RSC_CTRL_PDOWN    0
// Interrupt event positions
`define RSC_EV_LOWV       0
`define RSC_EV_LEVEL      1
`define RSC_EV_WDOG       2
`define RSC_EV_PIN        3
`define RSC_EV_SLEEP_TO   4
// Timing: times in microseconds, clock period in ns
`define RSC_CLK_NS        50
`define RSC_POR_US        50000
`define RSC_WDT_US        16700
`define RSC_POR_CYC       ((`RSC_POR_US * 1000) / `RSC_CLK_NS)
`define RSC_WDT_CYC       ((`RSC_WDT_US * 1000) / `RSC_CLK_NS)
`define RSC_PORT_RST      8'hFF
`endif

// ==== src/rsc_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for a level from outside the clock domain
module rsc_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Level in and out
  input  wire din,
  output reg  dout
);
  reg stage1;

  // First flop feeds only the second
  always @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ==== src/rsc_slow_tick.v ====
`timescale 1ns/1ps
// Slow oscillator tick: rising edges of synchronised slow clock
module rsc_slow_tick (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Slow clock pin and tick
  input  wire slow_osc_clock,
  output reg  tick
);
  wire slow_s;
  reg  slow_d;

  rsc_sync #(.RST_VAL(1'b0)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (slow_osc_clock),
    .dout    (slow_s)
  );

  // Edge detect on the synchronised level
  always @(posedge ref_clk) begin
    if (rst) begin
      slow_d <= 1'b0;
      tick   <= 1'b0;
    end else begin
      slow_d <= slow_s;
      tick   <= slow_s & ~slow_d;
    end
  end
endmodule

// ==== tb/rsc_monitor.sv ====
`timescale 1ns/1ps
// Port checker
module rsc_monitor (
  // Clock and reset
  input logic       ref_clk,
  input logic       rst,
  // Bus
  input logic       avs_read,
  input logic       avs_write,
  input logic       avs_waitrequest,
  // Sources and results
  input logic       ext_reset_n_pin,
  input logic       wdog_timeout,
  input logic       sleep_mode,
  input logic       core_reset,
  input logic       pc_sp_clear,
  input logic [7:0] port_dir_init,
  input logic       port_init_load,
  input logic [7:0] lowv_level_select,
  input logic       wdog_timeout_status,
  input logic       powerdown_status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Code is one of the four levels
  wire lv_ok = lowv_level_select inside {8'h55, 8'h33, 8'h99, 8'hAA};
  chk_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("no wait state");
  chk_pin_hold: assert property (!ext_reset_n_pin [*4] |=> core_reset)
    else $error("pin low without reset");
  chk_pin_settle: assert property ($rose(ext_reset_n_pin) |=> core_reset [*8])
    else $error("no settle after pin");
  chk_port_init: assert property (port_init_load |-> port_dir_init == 8'hFF)
    else $error("ports not inputs");
  chk_bad_restore: assert property (!lv_ok |-> ##[1:60] lowv_level_select == 8'h55)
    else $error("bad code kept");
  chk_bad_reset: assert property (!lv_ok |-> ##[1:60] core_reset)
    else $error("bad code no reset");
  chk_wdog_reset: assert property ($rose(wdog_timeout) && !sleep_mode
    |-> ##[1:8] (core_reset && wdog_timeout_status))
    else $error("time-out no reset");
  chk_sleep_flags: assert property (pc_sp_clear
    |=> wdog_timeout_status && powerdown_status && !core_reset)
    else $error("sleep time-out flags");
endmodule
bind rsc_reset_ctrl rsc_monitor mon (.ref_clk(ref_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ext_reset_n_pin(ext_reset_n_pin),
  .wdog_timeout(wdog_timeout), .sleep_mode(sleep_mode), .core_reset(core_reset),
  .pc_sp_clear(pc_sp_clear), .port_dir_init(port_dir_init), .port_init_load(port_init_load),
  .lowv_level_select(lowv_level_select), .wdog_timeout_status(wdog_timeout_status),
  .powerdown_status(powerdown_status));

// ==== tb/rsc_far_side.sv ====
`timescale 1ns/1ps
// Reset network, supply monitor, slow oscillator
module rsc_far_side (
  // Bench commands
  input  logic hold_pin,
  input  logic drop_supply,
  // Lines to the controller
  output logic ext_reset_n_pin,
  output logic low_supply,
  output logic slow_osc_clock
);
  // Pulled up unless held low
  assign ext_reset_n_pin = !hold_pin;
  assign low_supply = drop_supply;
  // Free-running oscillator
  initial begin
    slow_osc_clock = 1'b0;
    forever #170 slow_osc_clock = !slow_osc_clock;
  end
endmodule

// ==== tb/rsc_reset_ctrl_tb.sv ====
`timescale 1ns/1ps
// Bench for the reset controller
module rsc_reset_ctrl_tb;
  logic        ref_clk, rst, avs_read, avs_write, wdog_timeout, sleep_mode, irq;
  logic        hold_pin, drop_supply, ext_reset_n_pin, low_supply, slow_osc_clock;
  logic        avs_waitrequest, core_reset, pc_sp_clear, port_init_load, to_st, pd_st;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  pd_init, pc_init, lvs;
  logic [7:0]  codes [4] = '{8'h33, 8'h99, 8'hAA, 8'h55};
  integer      errors, checked, n, i;
  rsc_reset_ctrl #(.POR_CYCLES(50), .WDT_CYCLES(20), .LOWV_CYCLES(5)) uut (.ref_clk(ref_clk),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_reset_n_pin(ext_reset_n_pin),
    .low_supply(low_supply), .wdog_timeout(wdog_timeout), .slow_osc_clock(slow_osc_clock),
    .sleep_mode(sleep_mode), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
    .port_data_init(pd_init), .port_dir_init(pc_init), .port_init_load(port_init_load),
    .lowv_level_select(lvs), .wdog_timeout_status(to_st), .powerdown_status(pd_st), .irq(irq));
  rsc_far_side far (.hold_pin(hold_pin), .drop_supply(drop_supply),
    .ext_reset_n_pin(ext_reset_n_pin), .low_supply(low_supply), .slow_osc_clock(slow_osc_clock));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = !ref_clk;
  end
  task results;
    begin
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Access held until waitrequest low; read data kept in q
  task acc(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      chk(n < 20, 1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // Wait for reset, then count its length in n
  task rcyc;
    begin
      n = 0;
      while (core_reset !== 1'b1 && n < 80) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      n = 0;
      while (core_reset !== 1'b0 && n < 400) begin
        @(posedge ref_clk);
        n = n + 1;
      end
    end
  endtask
  // Low supply for len cycles
  task lowv(input integer len);
    begin
      @(posedge ref_clk);
      drop_supply <= 1'b1;
      repeat (len) @(posedge ref_clk);
      drop_supply <= 1'b0;
      repeat (15) @(posedge ref_clk);
    end
  endtask
  initial begin
    #400000;
    errors = errors + 1;
    results;
  end
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    wdog_timeout = 1'b0;
    sleep_mode = 1'b0;
    hold_pin = 1'b0;
    drop_supply = 1'b0;
    repeat (20) @(posedge ref_clk);
    chk({port_init_load, pd_init, pc_init}, 17'h1FFFF);
    rst <= 1'b0;
    rcyc;
    chk(n >= 50, 1);
    acc(0, 4'h0, 0); chk(q, 32'h55);
    acc(0, 4'h2, 0); chk(q[1:0], 2'b00);
    acc(0, 4'h7, 0); chk(q, 0);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, 4'h0, codes[i]);
      repeat (30) @(posedge ref_clk);
      acc(0, 4'h0, 0); chk({core_reset, q[7:0]}, {1'b0, codes[i]});
    end
    acc(1, 4'h5, 32'h1F);
    acc(1, 4'h1, 0);
    acc(1, 4'h0, 32'h12);
    rcyc; chk(n > 0, 1);
    acc(0, 4'h0, 0); chk(q, 32'h55);
    acc(0, 4'h1, 0); chk(q, 32'h2);
    chk(irq, 1);
    acc(1, 4'h5, 0); chk(irq, 0);
    acc(1, 4'h5, 32'h1F);
    acc(1, 4'h6, 32'h1F); chk(irq, 0);
    acc(1, 4'h1, 0); acc(0, 4'h1, 0); chk(q, 0);
    acc(1, 4'h0, 32'h99);
    lowv(2); chk(core_reset, 0);
    acc(1, 4'h3, 1);
    lowv(20); chk(core_reset, 0);
    acc(1, 4'h3, 0);
    lowv(20); rcyc; chk(n > 0, 1);
    acc(0, 4'h0, 0); chk(q, 32'h99);
    acc(0, 4'h1, 0); chk(q, 32'h4);
    @(posedge ref_clk);
    wdog_timeout <= 1'b1;
    rcyc; chk(n >= 20, 1);
    wdog_timeout <= 1'b0;
    acc(0, 4'h2, 0); chk(q[1:0], 2'b01);
    hold_pin <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk(core_reset, 1);
    hold_pin <= 1'b0;
    rcyc; chk(n >= 50, 1);
    acc(0, 4'h2, 0); chk(q[1:0], 2'b01);
    acc(1, 4'h2, 0);
    sleep_mode <= 1'b1;
    repeat (5) @(posedge ref_clk);
    wdog_timeout <= 1'b1;
    n = 0;
    while (pc_sp_clear !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n = n + 1;
    end
    chk({n < 20, core_reset}, 2'b10);
    wdog_timeout <= 1'b0;
    sleep_mode <= 1'b0;
    acc(0, 4'h2, 0); chk(q[1:0], 2'b11);
    acc(0, 4'h4, 0); chk(q, 32'h1D);
    chk(irq, 1);
    results;
  end
endmodule
